// ===== hdl/sab_regs.svh
// timing counts and field positions for the four-bank command tracker
`ifndef SAB_REGS_SVH
`define SAB_REGS_SVH
`define SAB_CLK_PERIOD_NS 25
`define SAB_PRECHARGE_TIME_NS 20
`define SAB_ACT_TO_COL_NS 20
`define SAB_WRITE_RECOVERY_NS 15
`define SAB_PRECHARGE_CYC ((`SAB_PRECHARGE_TIME_NS + `SAB_CLK_PERIOD_NS - 1) / `SAB_CLK_PERIOD_NS)
`define SAB_ACT_TO_COL_CYC ((`SAB_ACT_TO_COL_NS + `SAB_CLK_PERIOD_NS - 1) / `SAB_CLK_PERIOD_NS)
`define SAB_WRITE_RECOVERY_CYC ((`SAB_WRITE_RECOVERY_NS + `SAB_CLK_PERIOD_NS - 1) / `SAB_CLK_PERIOD_NS)
`define SAB_READ_LATENCY 3
`define SAB_BURST_LEN 4
`define SAB_AUTO_PRE_BIT 10
`define SAB_NUM_BANKS 4
`endif

// ===== hdl/sab_pkg.sv
// types shared by the bank tracker and its top
package sab_pkg;
  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE, BK_RECOVER, BK_PRECHARGING
  } sab_bank_state_t;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_TERMINATE,
    CMD_REFRESH, CMD_MODE, CMD_ILLEGAL
  } sab_cmd_t;
endpackage

// ===== hdl/sab_bank.sv
// one bank's state tracker
`timescale 1ns/1ps
`include "sab_regs.svh"
module sab_bank (
  input wire logic clk,
  input wire logic srst,
  input wire logic activate, // activate this bank
  input wire logic startRead, // read burst begins here
  input wire logic startWrite, // write burst begins here
  input wire logic autoPre, // burst carries auto precharge
  input wire logic precharge, // explicit precharge to this bank
  input wire logic interrupt, // burst cut by another bank or terminate
  input wire logic lastWord, // burst ran to its end
  output sab_pkg::sab_bank_state_t state,
  output logic apPending
);
  sab_pkg::sab_bank_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d; // timer for activate, recovery, precharge
  logic ap_q, ap_d; // auto precharge armed
  // next state of the bank
  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    ap_d = ap_q;
    unique case (state_q)
      sab_pkg::BK_IDLE: begin
        if (activate) begin
          state_d = sab_pkg::BK_ACTIVATING;
          cnt_d = 4'(`SAB_ACT_TO_COL_CYC - 1);
        end
      end
      sab_pkg::BK_ACTIVATING: begin
        if (cnt_q == 4'h0) begin
          state_d = sab_pkg::BK_ACTIVE;
        end
      end
      sab_pkg::BK_ACTIVE, sab_pkg::BK_READ, sab_pkg::BK_WRITE: begin
        if (precharge) begin
          state_d = sab_pkg::BK_PRECHARGING;
          cnt_d = 4'(`SAB_PRECHARGE_CYC - 1);
        end else if (startRead || startWrite) begin
          state_d = startRead ? sab_pkg::BK_READ : sab_pkg::BK_WRITE;
          ap_d = autoPre;
        end else if ((interrupt || lastWord) && state_q != sab_pkg::BK_ACTIVE) begin
          if (!ap_q) begin
            state_d = sab_pkg::BK_ACTIVE;
          end else if (state_q == sab_pkg::BK_WRITE) begin
            // recovery counted from the cutting command
            state_d = sab_pkg::BK_RECOVER;
            cnt_d = 4'(`SAB_WRITE_RECOVERY_CYC - 1);
          end else begin
            // read with auto precharge precharges at the cut
            state_d = sab_pkg::BK_PRECHARGING;
            cnt_d = 4'(`SAB_PRECHARGE_CYC - 1);
          end
        end
      end
      sab_pkg::BK_RECOVER: begin
        if (cnt_q == 4'h0) begin
          state_d = sab_pkg::BK_PRECHARGING;
          cnt_d = 4'(`SAB_PRECHARGE_CYC - 1);
        end
      end
      sab_pkg::BK_PRECHARGING: begin
        // idle only once precharge time has run out
        if (cnt_q == 4'h0) begin
          state_d = sab_pkg::BK_IDLE;
          ap_d = 1'b0;
        end
      end
      default: begin
        state_d = sab_pkg::BK_IDLE;
      end
    endcase
  end
  // state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= sab_pkg::BK_IDLE;
      cnt_q <= 4'h0;
      ap_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ap_q <= ap_d;
    end
  end
  assign state = state_q;
  assign apPending = ap_q;
endmodule

// ===== hdl/sab_core.sv
// four-bank command decoder, per-bank tracking and burst interruption
`timescale 1ns/1ps
`include "sab_regs.svh"
// Overview of operation
// - deselect or nop continues current operation
// - activate other bank while one busy
// - read other bank from activating/active/precharging
// - write other bank from activating/active/precharging
// - precharge to other bank leaves burst running
// - terminate ends most recent burst any bank
// - auto precharge bank precharges when interrupted
// - read cuts read, bus after latency
// - write cuts read at once, mask earlier
// - read cuts write; last word one before
// - write cuts write; last word one before
// - read cuts auto read; precharge at command
// - write cuts auto read; precharge at command
// - read cuts auto write; recovery then precharge
// - write cuts auto write; recovery then precharge
// - bank idle only after precharge time
// - any read/write may carry auto precharge
// - precharge to idle bank is nop
module sab_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEnPrev, // clock enable at previous edge
  input wire logic clkEn, // clock enable at this edge
  input wire logic chipSel_n, // chip select, active low
  input wire logic rowStrobe_n, // row strobe, active low
  input wire logic colStrobe_n, // column strobe, active low
  input wire logic writeStrobe_n, // write strobe, active low
  input wire logic [1:0] bankAddr, // bank address
  input wire logic [11:0] addr, // row/column address, bit 10 auto precharge
  input wire logic dataMask, // write data mask
  input wire logic [15:0] dataIn, // write data from controller
  output logic [15:0] dataOut, // read data to controller
  output logic dataOutEn, // high while device drives the data bus
  output logic writeAccept, // pulse: a write word was taken
  output logic [1:0] writeBank, // bank of the taken word
  output logic [15:0] writeData, // the taken word
  output logic [3:0] bankIdle, // per-bank idle flags
  output logic allIdle, // all banks idle
  output logic cmdError // pulse: command not legal in current state
);
  // read latency in clock cycles, one pipe stage each
  localparam int RL = `SAB_READ_LATENCY;
  // state and pending auto precharge of every bank tracker
  sab_pkg::sab_bank_state_t bkState [4];
  logic [3:0] bkAp;
  // one strobe per bank into the trackers
  logic [3:0] actV, rdV, wrV, preV, intV, lastV;
  // command decoded at this edge, nop when enable was low
  sab_pkg::sab_cmd_t cmd;
  // address bit 10: auto precharge, or all banks on a precharge
  logic autoPre;

  // burst tracking
  logic burstOn_q, burstOn_d;
  logic burstRead_q, burstRead_d;
  logic [1:0] burstBank_q, burstBank_d;
  logic [2:0] burstCnt_q, burstCnt_d;
  logic [15:0] dataCnt_q, dataCnt_d; // read data pattern source
  // read data pipeline, one stage per latency cycle
  logic [RL-1:0] rdPipe_q, rdPipe_d;
  // output flops and their next values
  logic [15:0] dataOut_q, dataOut_d;
  logic dataOutEn_q, dataOutEn_d;
  logic writeAccept_q, writeAccept_d;
  logic [1:0] writeBank_q, writeBank_d;
  logic [15:0] writeData_q, writeData_d;
  logic [3:0] bankIdle_q, bankIdle_d;
  logic allIdle_q, allIdle_d;
  logic cmdError_q, cmdError_d;

  // decode the strobes into a command
  function automatic sab_pkg::sab_cmd_t decodeCmd(input logic cs, input logic ras,
                                                   input logic cas, input logic we);
    // deselect, or all strobes high, is a no operation
    if (cs || {ras, cas, we} == 3'b111) begin
      decodeCmd = sab_pkg::CMD_NOP;
    end else begin
      // chip select low: the three strobes pick the command
      unique case ({ras, cas, we})
        3'b011: decodeCmd = sab_pkg::CMD_ACTIVE;
        3'b101: decodeCmd = sab_pkg::CMD_READ;
        3'b100: decodeCmd = sab_pkg::CMD_WRITE;
        3'b010: decodeCmd = sab_pkg::CMD_PRECHARGE;
        3'b110: decodeCmd = sab_pkg::CMD_TERMINATE;
        3'b001: decodeCmd = sab_pkg::CMD_REFRESH;
        3'b000: decodeCmd = sab_pkg::CMD_MODE;
        default: decodeCmd = sab_pkg::CMD_ILLEGAL;
      endcase
    end
  endfunction

  // true when a bank has its row open: active, reading or writing
  function automatic logic canColumn(input sab_pkg::sab_bank_state_t s);
    canColumn = (s == sab_pkg::BK_ACTIVE) || (s == sab_pkg::BK_READ) || (s == sab_pkg::BK_WRITE);
  endfunction

  // open row and no auto precharge pending: column commands and precharge may act
  function automatic logic colReady(input sab_pkg::sab_bank_state_t s, input logic ap);
    colReady = canColumn(s) && !ap;
  endfunction

  // commands are only acted on with clock enable high on both edges
  // a low enable on either edge turns the cycle into a nop
  assign cmd = (clkEnPrev && clkEn) ? decodeCmd(chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n)
                                    : sab_pkg::CMD_NOP;
  // bit 10 picks auto precharge on a column command
  assign autoPre = addr[`SAB_AUTO_PRE_BIT];

  // one tracker per bank
  genvar g;
  generate
    for (g = 0; g < `SAB_NUM_BANKS; g++) begin : gBank
      // each tracker sees only the strobes of its own bank
      sab_bank sab_bank_i (
        .clk(clk),
        .srst(srst),
        .activate(actV[g]),
        .startRead(rdV[g]),
        .startWrite(wrV[g]),
        .autoPre(autoPre),
        .precharge(preV[g]),
        .interrupt(intV[g]),
        .lastWord(lastV[g]),
        .state(bkState[g]),
        .apPending(bkAp[g])
      );
    end
  endgenerate

  // per-bank command steering and interruption
  always_comb begin
    // defaults: no strobe to any bank and no error
    actV = 4'h0;
    rdV = 4'h0;
    wrV = 4'h0;
    preV = 4'h0;
    intV = 4'h0;
    lastV = 4'h0;
    cmdError_d = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // commands addressed to bank i
      if (bankAddr == 2'(i)) begin
        unique case (cmd)
          sab_pkg::CMD_ACTIVE: begin
            // only an idle bank may open a row
            actV[i] = (bkState[i] == sab_pkg::BK_IDLE);
            cmdError_d = (bkState[i] != sab_pkg::BK_IDLE);
          end
          sab_pkg::CMD_READ: begin
            // read needs an open row and no auto precharge pending
            rdV[i] = colReady(bkState[i], bkAp[i]);
            cmdError_d = !colReady(bkState[i], bkAp[i]);
          end
          sab_pkg::CMD_WRITE: begin
            // write needs an open row and no auto precharge pending
            wrV[i] = colReady(bkState[i], bkAp[i]);
            cmdError_d = !colReady(bkState[i], bkAp[i]);
          end
          default: begin
            // other codes leave the addressed bank alone
          end
        endcase
      end
      // precharge to an idle bank does nothing all-bank when bit 10 set
      if (cmd == sab_pkg::CMD_PRECHARGE && (autoPre || bankAddr == 2'(i))) begin
        preV[i] = colReady(bkState[i], bkAp[i]);
      end
    end
    // refresh and mode load are refused unless every bank is idle
    if (cmd == sab_pkg::CMD_REFRESH || cmd == sab_pkg::CMD_MODE) begin
      cmdError_d = !(&bankIdle_q);
    end
    // reserved codes are always flagged
    if (cmd == sab_pkg::CMD_ILLEGAL) begin
      cmdError_d = 1'b1;
    end
    // a new burst in another bank, or terminate, cuts the running one
    if (burstOn_q) begin
      if (((cmd == sab_pkg::CMD_READ || cmd == sab_pkg::CMD_WRITE) && bankAddr != burstBank_q)
          || cmd == sab_pkg::CMD_TERMINATE) begin
        // the cut bank is the one that owns the running burst
        intV[burstBank_q] = 1'b1;
      end else if (burstCnt_q == 3'h1) begin
        // a burst that runs to its end closes its bank's burst state
        lastV[burstBank_q] = 1'b1;
      end
    end
  end

  // burst, data and status next values
  always_comb begin
    // defaults: hold the burst, shift the read pipe, no write pulse
    burstOn_d = burstOn_q;
    burstRead_d = burstRead_q;
    burstBank_d = burstBank_q;
    burstCnt_d = burstCnt_q;
    dataCnt_d = dataCnt_q;
    rdPipe_d = {rdPipe_q[RL-2:0], 1'b0};
    writeAccept_d = 1'b0;
    writeBank_d = writeBank_q;
    writeData_d = writeData_q;
    // an accepted read or write starts a fresh burst
    if (|(rdV | wrV)) begin
      // newest burst owns the bus; old burst ends here
      burstOn_d = 1'b1;
      burstRead_d = |rdV;
      burstBank_d = bankAddr;
      burstCnt_d = 3'(`SAB_BURST_LEN - 1);
    end else if (cmd == sab_pkg::CMD_TERMINATE) begin
      // terminate stops the latest burst whatever its bank
      burstOn_d = 1'b0;
    end else if (burstOn_q) begin
      // count down the running burst
      burstCnt_d = burstCnt_q - 3'h1;
      burstOn_d = (burstCnt_q != 3'h1);
    end
    // a read word is launched each cycle a read burst is live
    if (|rdV || (burstOn_q && burstRead_q && !(|wrV) && cmd != sab_pkg::CMD_TERMINATE
        && burstCnt_q != 3'h0)) begin
      // one pipe bit per word, read out a latency later
      rdPipe_d[0] = 1'b1;
    end
    // write data taken on the command edge and while the burst runs, unmasked only
    if ((|wrV || (burstOn_q && !burstRead_q && !(|rdV) && cmd != sab_pkg::CMD_TERMINATE
        && burstCnt_q != 3'h0)) && !dataMask) begin
      writeAccept_d = 1'b1;
      // the word goes to the newest write's bank
      writeBank_d = (|wrV) ? bankAddr : burstBank_q;
      writeData_d = dataIn;
    end
    // a write cuts read data at once
    if (|wrV) begin
      rdPipe_d = '0;
    end
    // output stage: a masked slot still uses up its word
    dataOutEn_d = rdPipe_q[RL-1] && !dataMask;
    dataOut_d = rdPipe_q[RL-1] ? dataCnt_q : dataOut_q;
    // next pattern word after each read word that reaches the output stage
    if (rdPipe_q[RL-1]) begin
      dataCnt_d = dataCnt_q + 16'h1;
    end
    // idle flags follow the bank trackers
    for (int i = 0; i < 4; i++) begin
      bankIdle_d[i] = (bkState[i] == sab_pkg::BK_IDLE);
    end
    allIdle_d = &bankIdle_d;
  end

  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      // reset values of every flop
      burstOn_q <= 1'b0;
      burstRead_q <= 1'b0;
      burstBank_q <= 2'h0;
      burstCnt_q <= 3'h0;
      dataCnt_q <= 16'h0;
      rdPipe_q <= '0;
      dataOut_q <= 16'h0;
      dataOutEn_q <= 1'b0;
      writeAccept_q <= 1'b0;
      writeBank_q <= 2'h0;
      writeData_q <= 16'h0;
      bankIdle_q <= 4'hF;
      allIdle_q <= 1'b1;
      cmdError_q <= 1'b0;
    end else begin
      // normal update from the next values
      burstOn_q <= burstOn_d;
      burstRead_q <= burstRead_d;
      burstBank_q <= burstBank_d;
      burstCnt_q <= burstCnt_d;
      dataCnt_q <= dataCnt_d;
      rdPipe_q <= rdPipe_d;
      dataOut_q <= dataOut_d;
      dataOutEn_q <= dataOutEn_d;
      writeAccept_q <= writeAccept_d;
      writeBank_q <= writeBank_d;
      writeData_q <= writeData_d;
      bankIdle_q <= bankIdle_d;
      allIdle_q <= allIdle_d;
      cmdError_q <= cmdError_d;
    end
  end
  // outputs straight from their flops
  assign dataOut = dataOut_q;
  assign dataOutEn = dataOutEn_q;
  assign writeAccept = writeAccept_q;
  assign writeBank = writeBank_q;
  assign writeData = writeData_q;
  assign bankIdle = bankIdle_q;
  assign allIdle = allIdle_q;
  assign cmdError = cmdError_q;
endmodule

// ===== verif/sab_core_sva.sv
// port checker for the four-bank tracker and its bind
`timescale 1ns/1ps
module sab_core_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEnPrev,
  input wire logic clkEn,
  input wire logic chipSel_n,
  input wire logic rowStrobe_n,
  input wire logic colStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic [1:0] bankAddr,
  input wire logic [11:0] addr,
  input wire logic dataMask,
  input wire logic [15:0] dataIn,
  input wire logic [15:0] dataOut,
  input wire logic dataOutEn,
  input wire logic writeAccept,
  input wire logic [1:0] writeBank,
  input wire logic [15:0] writeData,
  input wire logic [3:0] bankIdle,
  input wire logic allIdle,
  input wire logic cmdError
);
  // command decode as the device takes it
  wire logic vld = clkEnPrev & clkEn & ~chipSel_n;
  wire logic rdCmd = vld & rowStrobe_n & ~colStrobe_n & writeStrobe_n; // read
  wire logic wrCmd = vld & rowStrobe_n & ~colStrobe_n & ~writeStrobe_n; // write
  wire logic actCmd = vld & ~rowStrobe_n & colStrobe_n & writeStrobe_n; // activate
  wire logic nopCmd = vld & rowStrobe_n & colStrobe_n & writeStrobe_n; // no operation
  wire logic stop = vld & ~writeStrobe_n; // any code with write strobe low: write, precharge, terminate, mode
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // a read taken and left uncut and unmasked until its first word
  sequence sRdGo;
    rdCmd ##1 (!cmdError && !stop) ##1 !stop ##1 (!stop && !dataMask);
  endsequence
  // an activate that was taken
  sequence sActGo;
    actCmd ##1 !cmdError;
  endsequence
  a_read_latency: assert property (sRdGo |=> dataOutEn)
    else $error("read data missing after read latency");
  a_out_cause: assert property ($rose(dataOutEn) && !$past(dataMask, 2) |-> $past(rdCmd, 4))
    else $error("read data without a read four edges before");
  a_write_take: assert property (wrCmd && !dataMask |=> cmdError || (writeAccept &&
    writeBank == $past(bankAddr) && writeData == $past(dataIn)))
    else $error("write word not taken with its bank and data");
  a_nop_quiet: assert property (nopCmd |=> !cmdError)
    else $error("no operation flagged as error");
  a_enable_gate: assert property (!(clkEnPrev && clkEn) || chipSel_n |=> !cmdError)
    else $error("ignored cycle flagged as error");
  a_act_busy: assert property (sActGo |=> !bankIdle[$past(bankAddr, 2)])
    else $error("activated bank still reported idle");
  a_all_idle: assert property (allIdle |-> bankIdle == 4'hF)
    else $error("all idle while a bank is busy");
  a_reset_quiet: assert property ($fell(srst) |-> !dataOutEn && !writeAccept &&
    bankIdle == 4'hF && allIdle && !cmdError)
    else $error("outputs not at reset values");
endmodule
bind sab_core sab_core_sva sab_core_sva_i (.clk(clk), .srst(srst), .clkEnPrev(clkEnPrev), .clkEn(clkEn),
  .chipSel_n(chipSel_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n),
  .bankAddr(bankAddr), .addr(addr), .dataMask(dataMask), .dataIn(dataIn), .dataOut(dataOut),
  .dataOutEn(dataOutEn), .writeAccept(writeAccept), .writeBank(writeBank), .writeData(writeData),
  .bankIdle(bankIdle), .allIdle(allIdle), .cmdError(cmdError));

// ===== verif/sab_ctrl_model.sv
// controller model driving command, enable and write data pins
`timescale 1ns/1ps
module sab_ctrl_model (
  input wire logic clk,
  output logic clkEnPrev,
  output logic clkEn,
  output logic chipSel_n,
  output logic rowStrobe_n,
  output logic colStrobe_n,
  output logic writeStrobe_n,
  output logic [1:0] bankAddr,
  output logic [11:0] addr,
  output logic dataMask,
  output logic [15:0] dataIn
);
  logic ceOn = 1'b1; // bench request for clock enable
  // idle pins at time zero
  initial begin
    {chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n} = 4'h7;
    {clkEnPrev, clkEn, dataMask} = 3'h6;
    bankAddr = 2'h0;
    addr = 12'h000;
    dataIn = 16'h0000;
  end
  // enables move off the sampling edge; data changes every cycle
  always @(negedge clk) begin
    clkEnPrev <= clkEn;
    clkEn <= ceOn;
    dataIn <= dataIn + 16'h0001;
  end
  // one command for one edge, then no operation with inverted address
  task issue(input logic [3:0] code, input logic [1:0] b, input logic [11:0] a);
    @(negedge clk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n} = code;
    bankAddr = b;
    addr = a;
    @(negedge clk);
    {chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n} = 4'h7;
    bankAddr = ~b;
    addr = ~a;
  endtask
endmodule

// ===== verif/sab_core_test.sv
// self-checking bench for the four-bank tracker
`timescale 1ns/1ps
module sab_core_test;
  localparam logic [3:0] ACT = 4'h3, RD = 4'h5, WR = 4'h4, PRE = 4'h2, REF = 4'h1;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clkEnPrev, clkEn, chipSel_n, rowStrobe_n, colStrobe_n, writeStrobe_n, dataMask;
  logic dataOutEn, writeAccept, allIdle, cmdError;
  logic [1:0] bankAddr, writeBank;
  logic [11:0] addr;
  logic [15:0] dataIn, dataOut, writeData;
  logic [3:0] bankIdle;
  int failCount = 0; // mismatches
  int nCompared = 0; // comparisons
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  sab_ctrl_model sab_ctrl_model_i (.clk(clk), .clkEnPrev(clkEnPrev), .clkEn(clkEn), .chipSel_n(chipSel_n),
    .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n),
    .bankAddr(bankAddr), .addr(addr), .dataMask(dataMask), .dataIn(dataIn));
  sab_core sab_core_i (.clk(clk), .srst(srst), .clkEnPrev(clkEnPrev), .clkEn(clkEn), .chipSel_n(chipSel_n),
    .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n), .writeStrobe_n(writeStrobe_n),
    .bankAddr(bankAddr), .addr(addr), .dataMask(dataMask), .dataIn(dataIn), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .writeAccept(writeAccept), .writeBank(writeBank), .writeData(writeData),
    .bankIdle(bankIdle), .allIdle(allIdle), .cmdError(cmdError));
  // compare and count
  task chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
    sab_ctrl_model_i.issue(c, b, a);
  endtask
  // two banks opened, a busy bank refused
  task testActivate;
    op(ACT, 2'h0, 12'h000);
    step(2);
    chk(bankIdle, 4'hE);
    // the error flag stands only in the cycle after the command edge
    op(ACT, 2'h1, 12'h000);
    chk(cmdError, 1'b0);
    op(ACT, 2'h0, 12'h000);
    chk(cmdError, 1'b1);
    $display("done activate");
  endtask
  // read cut by a read to the other bank two edges later
  task testReadRead;
    int n;
    n = 0;
    fork
      begin op(RD, 2'h0, 12'h000); op(RD, 2'h1, 12'h000); end
      repeat (14) begin
        @(negedge clk);
        if (dataOutEn === 1'b1) begin
          chk(dataOut, 16'(n));
          n++;
        end
      end
    join
    chk(n, 6);
    $display("done read cut by read");
  endtask
  // write cut by a write to the other bank two edges later
  task testWriteWrite;
    int n;
    logic [11:0] seq;
    logic [15:0] last;
    n = 0;
    seq = 12'h000;
    fork
      begin op(WR, 2'h0, 12'h000); op(WR, 2'h1, 12'h000); end
      repeat (10) begin
        @(negedge clk);
        if (writeAccept === 1'b1) begin
          if (n > 0) chk(writeData, last + 16'h0001);
          last = writeData;
          seq = {seq[9:0], writeBank};
          n++;
        end
      end
    join
    chk(n, 6);
    chk(seq, 12'h055);
    $display("done write cut by write");
  endtask
  // auto precharge burst on bank 0 cut by bank 1; bank 0 must return idle
  task testApCut(input logic [3:0] c1, input logic [3:0] c2);
    op(PRE, 2'h0, 12'h000);
    op(ACT, 2'h0, 12'h000);
    op(c1, 2'h0, 12'h400);
    op(c2, 2'h1, 12'h000);
    step(10);
    chk(bankIdle[1:0], 2'h1);
    $display("done auto precharge cut");
  endtask
  // precharge to idle bank, refresh while busy, enable low, precharge all
  task testMisc;
    op(PRE, 2'h2, 12'h000);
    chk(cmdError, 1'b0);
    step(1);
    chk(bankIdle[2], 1'b1);
    op(REF, 2'h0, 12'h000);
    chk(cmdError, 1'b1);
    sab_ctrl_model_i.ceOn = 1'b0;
    op(ACT, 2'h2, 12'h000);
    step(3);
    chk(bankIdle[2], 1'b1);
    sab_ctrl_model_i.ceOn = 1'b1;
    step(2);
    op(PRE, 2'h0, 12'h400);
    step(4);
    chk(allIdle, 1'b1);
    chk(bankIdle, 4'hF);
    $display("done misc");
  endtask
  // counts, verdict and end of run
  task finishTest;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    step(12);
    srst = 1'b0;
    step(1);
    chk(bankIdle, 4'hF);
    chk(allIdle, 1'b1);
    testActivate;
    testReadRead;
    testWriteWrite;
    testApCut(RD, RD);
    testApCut(WR, WR);
    testApCut(RD, WR);
    testApCut(WR, RD);
    testMisc;
    finishTest;
  end
endmodule
